// ===== design/rtcia_device.sv
// Purpose: update and alarm interrupt logic of a real time clock
// Assumes: carries and BCD time arrive from logic on ref_clk
// Notes:   one open-drain active-low line shared by both sources
module rtcia_device (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // host side
   rtcia_if.device         bus,
   // clock core carries, one-cycle pulses
   input  wire logic       sec_carry,
   input  wire logic       min_carry,
   input  wire logic       hour_carry,
   // clock core BCD time
   input  wire logic [6:0] cur_sec,
   input  wire logic [6:0] cur_min,
   input  wire logic [5:0] cur_hour,
   input  wire logic [6:0] cur_weekday,
   input  wire logic [5:0] cur_day,
   // status
   output logic            update_active,
   output logic            alarm_active
);
   import rtcia_pkg::*;
   `include "rtcia_defines.svh"

   localparam logic [`RTCIA_RELEASE_W-1:0] RELEASE_CYC = `RTCIA_RELEASE_W'(`RTCIA_RELEASE_CYC);

   logic                         alarm_match;  // compare result
   logic                         update_event; // selected carry this cycle
   logic                         alarm_event;  // match on a second carry
   logic                         update_flag;  // sticky update flag
   logic                         alarm_flag;   // sticky alarm flag
   logic                         update_drive; // update source holds line low
   logic [`RTCIA_RELEASE_W-1:0]  release_cnt;  // cycles of low drive so far
   logic                         irq_oe;       // line drive

   // ----------------------------------------------------------------
   // alarm compare
   // ----------------------------------------------------------------
   rtcia_alarm_cmp u_cmp (
      .sec_reg     (bus.alarm_second_match),
      .min_reg     (bus.alarm_minute_match),
      .hour_reg    (bus.alarm_hour_match),
      .day_reg     (bus.alarm_day_match),
      .day_mode    (bus.day_mode_select),
      .cur_sec     (cur_sec),
      .cur_min     (cur_min),
      .cur_hour    (cur_hour),
      .cur_weekday (cur_weekday),
      .cur_day     (cur_day),
      .match       (alarm_match)
   );

   // ----------------------------------------------------------------
   // event decode
   // ----------------------------------------------------------------
   always_comb begin
      unique case (bus.update_sel)
         `RTCIA_SEL_SEC:  update_event = sec_carry;
         `RTCIA_SEL_MIN:  update_event = min_carry;
         `RTCIA_SEL_HOUR: update_event = hour_carry;
         `RTCIA_SEL_NONE: update_event = 1'b0;
      endcase
      alarm_event = sec_carry && alarm_match;
   end

   // ----------------------------------------------------------------
   // update flag: set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         update_flag <= 1'b0;
      end else if (update_event) begin
         update_flag <= 1'b1;
      end else if (bus.update_flag_clear) begin
         update_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // alarm flag: set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         alarm_flag <= 1'b0;
      end else if (alarm_event) begin
         alarm_flag <= 1'b1;
      end else if (bus.alarm_flag_clear) begin
         alarm_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // update drive with auto release timer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         update_drive <= 1'b0;
         release_cnt  <= '0;
      end else if (update_event && bus.update_irq_enable) begin
         update_drive <= 1'b1;
         release_cnt  <= '0;
      end else if (!bus.update_irq_enable || bus.update_flag_clear) begin
         update_drive <= 1'b0;
         release_cnt  <= '0;
      end else if (update_drive) begin
         if (release_cnt == RELEASE_CYC - 1'b1) begin
            update_drive <= 1'b0;
            release_cnt  <= '0;
         end else begin
            release_cnt  <= release_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // shared open-drain line, registered
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_oe <= 1'b0;
      end else begin
         irq_oe <= (update_drive && bus.update_irq_enable && !bus.update_flag_clear)
                || (alarm_flag && bus.alarm_irq_enable && !bus.alarm_flag_clear);
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         update_active <= 1'b0;
         alarm_active  <= 1'b0;
      end else begin
         update_active <= update_drive;
         alarm_active  <= alarm_flag && bus.alarm_irq_enable;
      end
   end

   assign bus.update_flag = update_flag;
   assign bus.alarm_flag  = alarm_flag;
   assign bus.irq_oe      = irq_oe;

endmodule

// ===== inc/rtcia_defines.svh
// Purpose: constants for the rtc update and alarm interrupt block
// Assumes: 25 MHz ref_clk
// Notes:   header holds definitions only
`ifndef RTCIA_DEFINES_SVH
`define RTCIA_DEFINES_SVH

// ----------------------------------------------------------------
// update event select codes {hi, lo}
// ----------------------------------------------------------------
`define RTCIA_SEL_SEC      2'h0
`define RTCIA_SEL_MIN      2'h1
`define RTCIA_SEL_HOUR     2'h2
`define RTCIA_SEL_NONE     2'h3
`define RTCIA_SEL_RESET    2'h0

// ----------------------------------------------------------------
// alarm field layout inside each 8-bit match register
// ----------------------------------------------------------------
`define RTCIA_SKIP_BIT     7
`define RTCIA_MATCH_RESET  8'h80

// ----------------------------------------------------------------
// timing: auto release of the interrupt line
// ----------------------------------------------------------------
`define RTCIA_CLK_HZ       25000000
`define RTCIA_RELEASE_US   7812
`define RTCIA_RELEASE_CYC  ((`RTCIA_RELEASE_US * (`RTCIA_CLK_HZ / 1000000)))
`define RTCIA_RELEASE_W    18

`endif

// ===== inc/rtcia_pkg.sv
// Purpose: shared types of the rtc update and alarm interrupt block
// Assumes: nothing
// Notes:   constants live in rtcia_defines.svh
package rtcia_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef logic [1:0] rtcia_sel_t;   // update event select {hi, lo}
   typedef logic [7:0] rtcia_reg_t;   // one alarm match register

   // host sequencer states
   typedef enum logic [3:0] {
      RTCIA_H_IDLE  = 4'h1,
      RTCIA_H_SETUP = 4'h2,
      RTCIA_H_CLEAR = 4'h4,
      RTCIA_H_ARM   = 4'h8
   } rtcia_hstate_t;

endpackage

// ===== inc/rtcia_if.sv
// Purpose: connection between the interrupt logic and its host
// Assumes: one clock domain
// Notes:   the open-drain line level is resolved here
interface rtcia_if;

   // ----------------------------------------------------------------
   // control and status pins written or read by the host
   // ----------------------------------------------------------------
   logic [1:0] update_sel;            // {update_sel_hi, update_sel_lo}
   logic       update_irq_enable;     // update interrupt enable
   logic       alarm_irq_enable;      // alarm interrupt enable
   logic       day_mode_select;       // 0 weekday mask, 1 day of month
   logic [7:0] alarm_second_match;    // skip, tens[2:0], units[3:0]
   logic [7:0] alarm_minute_match;    // skip, tens[2:0], units[3:0]
   logic [7:0] alarm_hour_match;      // skip, 0, tens[1:0], units[3:0]
   logic [7:0] alarm_day_match;       // skip, mask[6:0] or tens/units
   logic       update_flag_clear;     // one-cycle pulse: write 0 to flag
   logic       alarm_flag_clear;      // one-cycle pulse: write 0 to flag
   logic       update_flag;           // sticky update flag
   logic       alarm_flag;            // sticky alarm flag

   // ----------------------------------------------------------------
   // open-drain interrupt line
   // ----------------------------------------------------------------
   logic       irq_oe;                // device pulls low while high
   logic       irq_n;                 // resolved line level, pull-up

   assign irq_n = irq_oe ? 1'b0 : 1'b1;

   modport device (
      input  update_sel, update_irq_enable, alarm_irq_enable, day_mode_select,
      input  alarm_second_match, alarm_minute_match, alarm_hour_match, alarm_day_match,
      input  update_flag_clear, alarm_flag_clear,
      output update_flag, alarm_flag, irq_oe
   );

   modport host (
      output update_sel, update_irq_enable, alarm_irq_enable, day_mode_select,
      output alarm_second_match, alarm_minute_match, alarm_hour_match, alarm_day_match,
      output update_flag_clear, alarm_flag_clear,
      input  update_flag, alarm_flag, irq_n
   );

endinterface

// ===== design/rtcia_alarm_cmp.sv
// Purpose: combinational alarm compare of BCD time against match fields
// Assumes: time inputs are BCD from the clock core
// Notes:   used by the device end, evaluated on each second carry
module rtcia_alarm_cmp (
   // match registers
   input  wire logic [7:0] sec_reg,
   input  wire logic [7:0] min_reg,
   input  wire logic [7:0] hour_reg,
   input  wire logic [7:0] day_reg,
   input  wire logic       day_mode,
   // current time
   input  wire logic [6:0] cur_sec,
   input  wire logic [6:0] cur_min,
   input  wire logic [5:0] cur_hour,
   input  wire logic [6:0] cur_weekday,
   input  wire logic [5:0] cur_day,
   // result
   output logic            match
);
   import rtcia_pkg::*;
   `include "rtcia_defines.svh"

   logic sec_ok;   // second field matches or skipped
   logic min_ok;   // minute field matches or skipped
   logic hour_ok;  // hour field matches or skipped
   logic day_ok;   // day field matches or skipped

   // ----------------------------------------------------------------
   // per-field compare, skip bit forces a pass
   // ----------------------------------------------------------------
   always_comb begin
      sec_ok  = sec_reg[`RTCIA_SKIP_BIT] || (sec_reg[6:0] == cur_sec);
      min_ok  = min_reg[`RTCIA_SKIP_BIT] || (min_reg[6:0] == cur_min);
      hour_ok = hour_reg[`RTCIA_SKIP_BIT] || (hour_reg[5:0] == cur_hour);
      if (day_reg[`RTCIA_SKIP_BIT]) begin
         day_ok = 1'b1;
      end else if (day_mode) begin
         day_ok = (day_reg[5:0] == cur_day);
      end else begin
         day_ok = |(day_reg[6:0] & cur_weekday);
      end
      match = sec_ok && min_ok && hour_ok && day_ok;
   end

endmodule

// ===== design/rtcia_host.sv
// Purpose: host end: programs the interrupt logic in the proper order
// Assumes: user commands are one-cycle pulses on ref_clk
// Notes:   each step of a sequence takes one cycle
module rtcia_host (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // device side
   rtcia_if.host           bus,
   // user requests
   input  wire logic       upd_start,
   input  wire logic       upd_stop,
   input  wire logic [1:0] upd_sel_in,
   input  wire logic       alm_start,
   input  wire logic       alm_stop,
   input  wire logic [7:0] alarm_second_match_in,
   input  wire logic [7:0] alarm_minute_match_in,
   input  wire logic [7:0] alarm_hour_match_in,
   input  wire logic [7:0] alm_day_in,
   input  wire logic       alm_day_mode_in,
   input  wire logic       ack_update,
   input  wire logic       ack_alarm,
   // user status
   output logic            busy,
   output logic            irq_seen,
   output logic            update_flag_seen,
   output logic            alarm_flag_seen
);
   import rtcia_pkg::*;
   `include "rtcia_defines.svh"

   rtcia_hstate_t state;        // sequencer state
   logic          is_alarm;     // sequence targets the alarm
   logic          is_disable;   // sequence disables only
   logic [1:0]    sel_q;        // update select
   logic          upd_en_q;     // update enable
   logic          alm_en_q;     // alarm enable
   logic          mode_q;       // day mode
   logic [7:0]    sec_q;        // alarm match registers
   logic [7:0]    min_q;
   logic [7:0]    hour_q;
   logic [7:0]    day_q;
   logic          uclr_q;       // flag clear pulses
   logic          aclr_q;
   logic [1:0]    irq_sync;     // line synchroniser

   // ----------------------------------------------------------------
   // programming sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= RTCIA_H_IDLE; is_alarm <= 1'b0; is_disable <= 1'b0;
         sel_q <= `RTCIA_SEL_RESET; upd_en_q <= 1'b0; alm_en_q <= 1'b0; mode_q <= 1'b0;
         sec_q <= `RTCIA_MATCH_RESET; min_q <= `RTCIA_MATCH_RESET;
         hour_q <= `RTCIA_MATCH_RESET; day_q <= `RTCIA_MATCH_RESET;
         uclr_q <= 1'b0; aclr_q <= 1'b0;
      end else begin
         uclr_q <= ack_update && (state == RTCIA_H_IDLE);
         aclr_q <= ack_alarm && (state == RTCIA_H_IDLE);
         unique case (state)
            RTCIA_H_IDLE: begin
               if (upd_start || upd_stop) begin
                  upd_en_q <= 1'b0;
                  is_alarm <= 1'b0; is_disable <= upd_stop;
                  state <= upd_stop ? RTCIA_H_CLEAR : RTCIA_H_SETUP;
               end else if (alm_start || alm_stop) begin
                  alm_en_q <= 1'b0;
                  is_alarm <= 1'b1; is_disable <= alm_stop;
                  state <= alm_stop ? RTCIA_H_CLEAR : RTCIA_H_SETUP;
               end
            end
            RTCIA_H_SETUP: begin
               if (is_alarm) begin
                  sec_q <= alarm_second_match_in; min_q <= alarm_minute_match_in;
                  hour_q <= alarm_hour_match_in; day_q <= alm_day_in;
                  mode_q <= alm_day_mode_in;
               end else begin
                  sel_q <= upd_sel_in;
               end
               state <= RTCIA_H_CLEAR;
            end
            RTCIA_H_CLEAR: begin
               if (is_alarm) aclr_q <= 1'b1; else uclr_q <= 1'b1;
               state <= is_disable ? RTCIA_H_IDLE : RTCIA_H_ARM;
            end
            RTCIA_H_ARM: begin
               if (is_alarm) alm_en_q <= 1'b1; else upd_en_q <= 1'b1;
               state <= RTCIA_H_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupt line and flag observation
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_sync <= 2'h3; irq_seen <= 1'b0; update_flag_seen <= 1'b0;
         alarm_flag_seen <= 1'b0; busy <= 1'b0;
      end else begin
         irq_sync <= {irq_sync[0], bus.irq_n};
         irq_seen <= !irq_sync[1];
         update_flag_seen <= bus.update_flag;
         alarm_flag_seen <= bus.alarm_flag;
         busy <= (state != RTCIA_H_IDLE);
      end
   end

   assign bus.update_sel         = sel_q;
   assign bus.update_irq_enable  = upd_en_q;
   assign bus.alarm_irq_enable   = alm_en_q;
   assign bus.day_mode_select    = mode_q;
   assign bus.alarm_second_match = sec_q;
   assign bus.alarm_minute_match = min_q;
   assign bus.alarm_hour_match   = hour_q;
   assign bus.alarm_day_match    = day_q;
   assign bus.update_flag_clear  = uclr_q;
   assign bus.alarm_flag_clear   = aclr_q;

endmodule

// ===== dv/rtcia_sva.sv
// Purpose: assertions on the link between the interrupt logic and its host
// Assumes: one clock, resetn asynchronous and active low
// Notes:   takes the interface signals and carries as plain inputs
`include "rtcia_defines.svh"
module rtcia_sva (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       resetn,
   // clock core carries
   input wire logic       sec_carry,
   input wire logic       min_carry,
   input wire logic       hour_carry,
   // host controls
   input wire logic [1:0] update_sel,
   input wire logic       update_irq_enable,
   input wire logic       alarm_irq_enable,
   input wire logic [7:0] alarm_second_match,
   input wire logic [7:0] alarm_minute_match,
   input wire logic [7:0] alarm_hour_match,
   input wire logic [7:0] alarm_day_match,
   input wire logic       update_flag_clear,
   input wire logic       alarm_flag_clear,
   // device status
   input wire logic       update_flag,
   input wire logic       alarm_flag,
   input wire logic       irq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REL = `RTCIA_RELEASE_CYC;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   logic upd_hit;   // selected carry this cycle
   logic alm_req;   // alarm source wants the line
   logic any_req;   // either source wants the line
   logic all_skip;  // every alarm field excluded
   int   low_cnt;   // cycles of drive with no alarm request
   assign upd_hit = (sec_carry && update_sel == `RTCIA_SEL_SEC) || (min_carry && update_sel == `RTCIA_SEL_MIN)
                    || (hour_carry && update_sel == `RTCIA_SEL_HOUR);
   assign alm_req = alarm_flag && alarm_irq_enable;
   assign any_req = alm_req || (update_flag && update_irq_enable);
   assign all_skip = alarm_second_match[7] && alarm_minute_match[7] && alarm_hour_match[7] && alarm_day_match[7];
   // counts how long the update drive has held the line
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_cnt <= 0;
      end else if (irq_oe && !alm_req) begin
         low_cnt <= low_cnt + 1;
      end else begin
         low_cnt <= 0;
      end
   end
   sequence s_upd_set;
      upd_hit && update_irq_enable;
   endsequence
   sequence s_upd_keep;
      update_irq_enable && !update_flag_clear;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_upd_set_cause: assert property ($rose(update_flag) |-> $past(upd_hit))
      else $error("update flag rose without a selected carry");
   a_upd_flag_set: assert property (upd_hit |=> update_flag)
      else $error("selected carry did not set update flag");
   a_upd_flag_hold: assert property (update_flag && !update_flag_clear |=> update_flag)
      else $error("update flag dropped without a clear");
   a_upd_drive_low: assert property (s_upd_set ##1 s_upd_keep |=> irq_oe)
      else $error("enabled update did not pull the line");
   a_upd_en_release: assert property ($fell(update_irq_enable) && !alm_req |=> !irq_oe)
      else $error("line held after update enable dropped");
   a_upd_clr_release: assert property (update_flag_clear && !upd_hit && !alm_req |=> !irq_oe)
      else $error("line held after update flag clear");
   a_upd_auto_release: assert property (low_cnt <= REL)
      else $error("update drive outlasted the release time");
   a_alm_set_cause: assert property ($rose(alarm_flag) |-> $past(sec_carry))
      else $error("alarm flag rose without a second carry");
   a_alm_every_sec: assert property (sec_carry && all_skip |=> alarm_flag)
      else $error("all fields skipped but no alarm");
   a_alm_drive_low: assert property (alm_req && !alarm_flag_clear |=> irq_oe)
      else $error("enabled alarm did not pull the line");
   a_alm_clr_release: assert property (alarm_flag_clear && !update_flag && !upd_hit |=> !irq_oe)
      else $error("line held after alarm flag clear");
   a_alm_en_release: assert property (!alarm_irq_enable && !update_flag |=> !irq_oe)
      else $error("line held with alarm enable low");
   a_line_shared: assert property (irq_oe |-> $past(any_req))
      else $error("line pulled with no source requesting");
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for both ends of the interrupt link
// Assumes: 25 MHz ref_clk, the two ends joined by rtcia_if
// Notes:   the full auto release time is waited once
`include "rtcia_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REL = `RTCIA_RELEASE_CYC;
   // clock, reset, clock core side
   logic       ref_clk, resetn, sec_carry, min_carry, hour_carry;
   logic [6:0] cur_sec, cur_min, cur_weekday;
   logic [5:0] cur_hour, cur_day;
   // host user side
   logic       upd_start, upd_stop, alm_start, alm_stop, ack_update, ack_alarm;
   logic       alm_day_mode_in, busy, ua, aa, iq, uf, af;
   logic [1:0] upd_sel_in;
   logic [7:0] alarm_second_match_in, alarm_minute_match_in, alarm_hour_match_in, alm_day_in;
   int         n_mismatch, check_count;
   rtcia_if bus_if();
   rtcia_device rtcia_device_i (.ref_clk, .resetn, .bus(bus_if), .sec_carry, .min_carry, .hour_carry, .cur_sec,
      .cur_min, .cur_hour, .cur_weekday, .cur_day, .update_active(ua), .alarm_active(aa));
   rtcia_host rtcia_host_i (.ref_clk, .resetn, .bus(bus_if), .upd_start, .upd_stop, .upd_sel_in, .alm_start,
      .alm_stop, .alarm_second_match_in, .alarm_minute_match_in, .alarm_hour_match_in, .alm_day_in, .alm_day_mode_in, .ack_update, .ack_alarm,
      .busy, .irq_seen(iq), .update_flag_seen(uf), .alarm_flag_seen(af));
   rtcia_sva rtcia_sva_i (.ref_clk, .resetn, .sec_carry, .min_carry, .hour_carry, .update_sel(bus_if.update_sel),
      .update_irq_enable(bus_if.update_irq_enable), .alarm_irq_enable(bus_if.alarm_irq_enable),
      .alarm_second_match(bus_if.alarm_second_match), .alarm_minute_match(bus_if.alarm_minute_match),
      .alarm_hour_match(bus_if.alarm_hour_match), .alarm_day_match(bus_if.alarm_day_match),
      .update_flag_clear(bus_if.update_flag_clear), .alarm_flag_clear(bus_if.alarm_flag_clear),
      .update_flag(bus_if.update_flag), .alarm_flag(bus_if.alarm_flag), .irq_oe(bus_if.irq_oe));
   // ----------------------------------------------------------------
   // clock, checks and helpers
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   // two-digit value to packed tens and units
   function automatic logic [7:0] bcd(input int v);
      return 8'(((v / 10) << 4) | (v % 10));
   endfunction
   // reference alarm compare, skip bit 7 drops a field
   function automatic logic mdl(input logic [7:0] fs, fm, fh, fd, input logic md, input int s, m, h, d, wd);
      logic ok;
      ok = 1'b1;
      if (!fs[7] && fs[6:0] != bcd(s) % 128) ok = 1'b0;
      if (!fm[7] && fm[6:0] != bcd(m) % 128) ok = 1'b0;
      if (!fh[7] && fh[5:0] != bcd(h) % 64) ok = 1'b0;
      if (!fd[7] && md && fd[5:0] != bcd(d) % 64) ok = 1'b0;
      if (!fd[7] && !md && (fd[6:0] & wd[6:0]) == 0) ok = 1'b0;
      return ok;
   endfunction
   // one user command pulse, then wait for the host to go idle
   task automatic cmd(input int c);
      int n;
      @(posedge ref_clk);
      case (c)
         0: upd_start <= 1'b1;
         1: upd_stop <= 1'b1;
         2: alm_start <= 1'b1;
         3: alm_stop <= 1'b1;
         4: ack_update <= 1'b1;
         default: ack_alarm <= 1'b1;
      endcase
      @(posedge ref_clk);
      {upd_start, upd_stop, alm_start, alm_stop, ack_update, ack_alarm} <= 6'h00;
      repeat (3) @(posedge ref_clk);
      for (n = 0; n < 20 && busy !== 1'b0; n++) @(posedge ref_clk);
      if (n == 20) begin
         chk("busy", 0, busy);
         complete_run();
      end
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // one-cycle carry pulse: 0 second, 1 minute, 2 hour
   task automatic carry(input int k);
      @(posedge ref_clk);
      sec_carry <= (k == 0);
      min_carry <= (k == 1);
      hour_carry <= (k == 2);
      @(posedge ref_clk);
      {sec_carry, min_carry, hour_carry} <= 3'h0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int i, j, s, m, h, d, wd, msk, cnt;
      logic [7:0] fs, fm, fh, fd;
      logic md, ex;
      void'($urandom(49));
      {resetn, sec_carry, min_carry, hour_carry, cur_sec, cur_min, cur_weekday, cur_hour, cur_day} = '0;
      {upd_start, upd_stop, alm_start, alm_stop, ack_update, ack_alarm, alm_day_mode_in, upd_sel_in} = '0;
      {alarm_second_match_in, alarm_minute_match_in, alarm_hour_match_in, alm_day_in} = {4{8'h80}};
      n_mismatch = 0;
      check_count = 0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(negedge ref_clk);
      chk("irq_n", 1, bus_if.irq_n);
      chk("update_flag", 0, bus_if.update_flag);
      // every select code against every carry kind
      for (i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         upd_sel_in <= 2'(i / 3);
         cmd(0);
         carry(i % 3);
         ex = (i / 3 == i % 3);
         chk("update_flag", {3{ex}}, {bus_if.update_flag, ua, uf});
         chk("irq_n", !ex, bus_if.irq_n);
         cmd(4);
         chk("update_flag", 0, bus_if.update_flag);
         chk("irq_n", 1, bus_if.irq_n);
      end
      $display("test update_select done");
      // automatic release keeps the flag
      @(posedge ref_clk);
      upd_sel_in <= 2'h0;
      cmd(0);
      carry(0);
      for (cnt = 0; cnt < REL + 20 && bus_if.irq_n !== 1'b1; cnt++) @(negedge ref_clk);
      chk("release_cycles", REL - 1, cnt);
      if (cnt == REL + 20) complete_run();
      chk("irq_seen", 1, iq);
      chk("update_flag", 1, bus_if.update_flag);
      cmd(4);
      carry(0);
      chk("irq_n", 0, bus_if.irq_n);
      cmd(1);
      chk("irq_n", 1, bus_if.irq_n);
      chk("update_flag", 0, bus_if.update_flag);
      @(posedge ref_clk);
      upd_sel_in <= 2'h3;
      cmd(0);
      cmd(1);
      $display("test update_release done");
      // random alarm fields, both day modes, two seconds each
      for (i = 0; i < 24; i++) begin
         s = $urandom % 60;
         m = $urandom % 60;
         h = $urandom % 24;
         d = 1 + $urandom % 31;
         wd = 1 << ($urandom % 7);
         md = ((i / 2) % 2 == 1);
         fs = bcd((i < 2 || $urandom % 3 != 0) ? s : $urandom % 60);
         fm = bcd((i < 2 || $urandom % 3 != 0) ? m : $urandom % 60);
         fh = bcd((i < 2 || $urandom % 3 != 0) ? h : $urandom % 24);
         msk = (i < 2 || $urandom % 3 != 0) ? (($urandom % 128) | wd) : (($urandom % 128) & ~wd);
         fd = md ? bcd((i < 2 || $urandom % 3 != 0) ? d : 1 + $urandom % 31) : 8'(msk % 128);
         fs[7] = (i < 2) || ($urandom % 4 == 0);
         fm[7] = (i == 0) || ($urandom % 4 == 0);
         fh[7] = (i == 0) || ($urandom % 4 == 0);
         fd[7] = (i == 0) || ($urandom % 4 == 0);
         @(posedge ref_clk);
         {alarm_second_match_in, alarm_minute_match_in, alarm_hour_match_in, alm_day_in, alm_day_mode_in} <= {fs, fm, fh, fd, md};
         cmd(2);
         for (j = 0; j < 2; j++) begin
            if (j == 1) s = (s + 1 + $urandom % 58) % 60;
            @(posedge ref_clk);
            {cur_sec, cur_min, cur_hour, cur_day} <= {7'(bcd(s)), 7'(bcd(m)), 6'(bcd(h)), 6'(bcd(d))};
            cur_weekday <= 7'(wd);
            carry(0);
            ex = mdl(fs, fm, fh, fd, md, s, m, h, d, wd);
            chk("alarm_flag", {3{ex}}, {bus_if.alarm_flag, aa, af});
            chk("irq_n", !ex, bus_if.irq_n);
            cmd((j == 1 && i % 2 == 1) ? 3 : 5);
            chk("irq_n", 1, bus_if.irq_n);
            chk("alarm_flag", 0, bus_if.alarm_flag);
         end
      end
      $display("test alarm_match done");
      complete_run();
   end
endmodule
